//--- logic/cfg_if.sv
// configuration port between controller and transceiver
// assumes both ends on the same clock; one access per cycle while sel_n low
`timescale 1ns/1ps
`default_nettype none
interface cfg_if;
  logic sel_n;
  logic we;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport dev (input sel_n, input we, input addr, input wdata, output rdata);
  modport host (output sel_n, output we, output addr, output wdata, input rdata);
endinterface
`default_nettype wire

//--- logic/power_seq_host.sv
// controller end: runs reset, configure, calibrate and rx/tx/pd moves
// assumes axi4-lite software side and the transceiver on the same clock
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module power_seq_host import seq_pkg::*; #(
  parameter int TURN_ON_CYCLES = TURN_ON_CYC,
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  cfg_if.host cfg
);
  if (TURN_ON_CYCLES < 1 || LOCK_CYCLES < 1) begin : g_chk
    $error("settling counts must be at least 1");
  end
  hstate_t state_reg, state_next;
  mode_t mode_reg, tgt_reg, tgt_next, cmd_tgt;
  logic init_reg, woke_reg, calibrated_reg;
  logic [31:0] cnt_reg, turn_on_reg, lock_reg, bias_reg;
  logic wait_reg;
  logic sel_n_reg, we_reg;
  logic [2:0] addr_reg;
  logic [7:0] wdata_reg;
  logic w_take, r_take, ctrl_wr, go_init, go_move, busy;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // main word for a target; wake powers only synth and oscillator
  function automatic logic [7:0] main_word(input mode_t t, input logic wake);
    logic [7:0] m;
    m = MAIN_RST;
    m[MAIN_XOSC_PD] = 1'b0;
    m[MAIN_SYNTH_PD] = (t == M_PD);
    m[MAIN_RX_PD] = !(t == M_RX && !wake);
    m[MAIN_TX_PD] = !(t == M_TX && !wake);
    m[MAIN_FREQ_SEL] = (t == M_TX);
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign busy = (state_reg != S_IDLE);
  assign w_take = awvalid && wvalid && !bvalid;
  assign awready = w_take;
  assign wready = w_take;
  assign arready = !rvalid;
  assign r_take = arvalid && !rvalid;
  assign ctrl_wr = w_take && awaddr == R_CTRL && wstrb[0];
  // commands while busy, or moves before calibration, are dropped
  assign go_init = ctrl_wr && !busy && wdata[CTRL_INIT];
  assign go_move = ctrl_wr && !busy && calibrated_reg && !wdata[CTRL_INIT] &&
                   (wdata[CTRL_RX] || wdata[CTRL_TX] || wdata[CTRL_PD]);
  always_comb begin
    if (wdata[CTRL_RX]) begin
      cmd_tgt = M_RX;
    end else if (wdata[CTRL_TX]) begin
      cmd_tgt = M_TX;
    end else begin
      cmd_tgt = M_PD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (w_take) begin
      bvalid <= 1'b1;
      case (awaddr)
        R_CTRL, R_STATUS, R_TURN_ON, R_LOCK, R_BIAS: bresp <= RESP_OKAY;
        default: bresp <= RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      turn_on_reg <= 32'(TURN_ON_CYCLES);
      lock_reg <= 32'(LOCK_CYCLES);
      bias_reg <= BIAS_RST;
    end else if (w_take) begin
      case (awaddr)
        R_TURN_ON: turn_on_reg <= merge(turn_on_reg, wdata, wstrb);
        R_LOCK: lock_reg <= merge(lock_reg, wdata, wstrb);
        R_BIAS: bias_reg <= merge(bias_reg, wdata, wstrb);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (r_take) begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (araddr)
        R_CTRL: rdata <= 32'h0000_0000;
        R_STATUS: rdata <= {24'h00_0000, state_reg, mode_reg, calibrated_reg, busy};
        R_TURN_ON: rdata <= turn_on_reg;
        R_LOCK: rdata <= lock_reg;
        R_BIAS: rdata <= bias_reg;
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    tgt_next = tgt_reg;
    case (state_reg)
      S_IDLE: begin
        if (go_init) begin
          state_next = S_RST_LO;
          tgt_next = M_RX;
        end else if (go_move) begin
          tgt_next = cmd_tgt;
          if (cmd_tgt == M_PD) begin
            state_next = S_SETUP;
          end else if (mode_reg == M_PD) begin
            state_next = S_WAKE;
          end else if (mode_reg != cmd_tgt) begin
            state_next = S_SETUP;
          end
        end
      end
      S_RST_LO: state_next = S_RST_HI;
      S_RST_HI: state_next = S_CFG_OSC;
      S_CFG_OSC: state_next = S_CFG_RX;
      S_CFG_RX: state_next = S_CFG_BUF;
      S_CFG_BUF: state_next = S_WAKE;
      S_WAKE: state_next = init_reg ? S_CAL : S_SETUP;
      S_CAL: state_next = S_CAL_WAIT;
      S_CAL_WAIT: begin
        if (!wait_reg && cfg.rdata[STAT_CAL_DONE]) begin
          if (tgt_reg == M_RX) begin
            state_next = S_WAKE;
            tgt_next = M_TX;
          end else begin
            state_next = S_SETUP;
            tgt_next = M_PD;
          end
        end
      end
      S_SETUP: state_next = (tgt_reg == M_PD) ? S_IDLE : S_SETTLE;
      S_SETTLE: state_next = (cnt_reg <= 32'h1) ? S_IDLE : S_SETTLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= S_IDLE;
      tgt_reg <= M_PD;
    end else begin
      state_reg <= state_next;
      tgt_reg <= tgt_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_reg <= M_OFF;
      init_reg <= 1'b0;
      calibrated_reg <= 1'b0;
    end else if (state_reg == S_IDLE && go_init) begin
      init_reg <= 1'b1;
      calibrated_reg <= 1'b0;
      mode_reg <= M_OFF;
    end else if (state_reg == S_SETUP) begin
      mode_reg <= tgt_reg;
      if (init_reg) begin
        init_reg <= 1'b0;
        calibrated_reg <= 1'b1;
      end
    end
  end

  // settle count picks turn-on after a wake, lock after a switch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      woke_reg <= 1'b0;
      cnt_reg <= 32'h0;
      wait_reg <= 1'b0;
    end else begin
      if (state_reg == S_IDLE) begin
        woke_reg <= 1'b0;
      end else if (state_reg == S_WAKE) begin
        woke_reg <= 1'b1;
      end
      if (state_reg == S_SETUP) begin
        cnt_reg <= woke_reg ? turn_on_reg : lock_reg;
      end else if (cnt_reg != 32'h0) begin
        cnt_reg <= cnt_reg - 32'h1;
      end
      // status read lags a cycle; skip the first sample
      wait_reg <= (state_reg == S_CAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel_n_reg <= 1'b1;
      we_reg <= 1'b0;
      addr_reg <= A_MAIN;
      wdata_reg <= 8'h00;
    end else begin
      sel_n_reg <= 1'b0;
      we_reg <= 1'b1;
      addr_reg <= A_MAIN;
      wdata_reg <= 8'h00;
      case (state_next)
        S_RST_LO: begin
          wdata_reg <= MAIN_RST & ~(8'h01 << MAIN_RESET_N);
        end
        S_RST_HI: wdata_reg <= MAIN_RST;
        S_CFG_OSC: begin
          addr_reg <= A_OSC_BIAS;
          wdata_reg <= bias_reg[7:0];
        end
        S_CFG_RX: begin
          addr_reg <= A_RX_BIAS;
          wdata_reg <= bias_reg[15:8];
        end
        S_CFG_BUF: begin
          addr_reg <= A_BUF_BIAS;
          wdata_reg <= bias_reg[23:16];
        end
        S_WAKE: wdata_reg <= main_word(tgt_next, 1'b1);
        S_CAL: begin
          addr_reg <= A_CAL;
          wdata_reg <= 8'h01 << CAL_START;
        end
        S_CAL_WAIT: begin
          we_reg <= 1'b0;
          addr_reg <= A_STATUS;
        end
        S_SETUP: wdata_reg <= main_word(tgt_next, 1'b0);
        default: begin
          sel_n_reg <= 1'b1;
          we_reg <= 1'b0;
        end
      endcase
    end
  end
  assign cfg.sel_n = sel_n_reg;
  assign cfg.we = we_reg;
  assign cfg.addr = addr_reg;
  assign cfg.wdata = wdata_reg;
endmodule
`default_nettype wire

//--- logic/seq_pkg.sv
// shared constants for the power sequencer pair: device map, fields, timing
// assumes one 250 MHz clock for both ends
package seq_pkg;
  localparam int CLK_MHZ = 250;
  // settling times in microseconds, narrowest and widest loop filter
  localparam int TURN_ON_US_NARROW = 3200;
  localparam int TURN_ON_US_WIDE = 700;
  localparam int LOCK_US_307K = 900;
  localparam int LOCK_US_CHAN = 180;
  localparam int LOCK_US_1M = 1300;
  localparam int TURN_ON_CYC = TURN_ON_US_NARROW * CLK_MHZ;
  localparam int LOCK_CYC = LOCK_US_1M * CLK_MHZ;
  localparam int CAL_CYC_DEF = 64;
  // device map
  localparam logic [2:0] A_MAIN = 3'h0;
  localparam logic [2:0] A_CAL = 3'h1;
  localparam logic [2:0] A_FREQ_FIRST = 3'h2;
  localparam logic [2:0] A_FREQ_SECOND = 3'h3;
  localparam logic [2:0] A_OSC_BIAS = 3'h4;
  localparam logic [2:0] A_RX_BIAS = 3'h5;
  localparam logic [2:0] A_BUF_BIAS = 3'h6;
  localparam logic [2:0] A_STATUS = 3'h7;
  localparam int MAIN_RX_PD = 0;
  localparam int MAIN_TX_PD = 1;
  localparam int MAIN_SYNTH_PD = 2;
  localparam int MAIN_XOSC_PD = 3;
  localparam int MAIN_FREQ_SEL = 4;
  localparam int MAIN_RESET_N = 7;
  localparam int CAL_START = 0;
  localparam int STAT_CAL_DONE = 0;
  localparam int STAT_CAL_BUSY = 1;
  localparam logic [7:0] MAIN_RST = 8'h8f;
  localparam logic [7:0] FREQ_RST = 8'h00;
  localparam logic [7:0] OSC_BIAS_RST = 8'h88;
  localparam logic [7:0] RX_BIAS_RST = 8'h44;
  localparam logic [7:0] BUF_BIAS_RST = 8'h44;
  // controller registers on axi4-lite
  localparam int AXI_AW = 8;
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_STATUS = 8'h04;
  localparam logic [7:0] R_TURN_ON = 8'h08;
  localparam logic [7:0] R_LOCK = 8'h0c;
  localparam logic [7:0] R_BIAS = 8'h10;
  localparam int CTRL_INIT = 0;
  localparam int CTRL_RX = 1;
  localparam int CTRL_TX = 2;
  localparam int CTRL_PD = 3;
  localparam logic [31:0] BIAS_RST = 32'h0044_4488;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    M_PD = 2'h0, M_RX = 2'h1, M_TX = 2'h2, M_OFF = 2'h3
  } mode_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_RST_LO = 4'h1, S_RST_HI = 4'h2, S_CFG_OSC = 4'h3,
    S_CFG_RX = 4'h4, S_CFG_BUF = 4'h5, S_WAKE = 4'h6, S_CAL = 4'h7,
    S_CAL_WAIT = 4'h8, S_SETUP = 4'h9, S_SETTLE = 4'ha
  } hstate_t;
endpackage

//--- logic/transceiver_power_sequencer.sv
// transceiver end: power control, bias and calibration registers
// assumes the controller drives cfg on the same clock
`timescale 1ns/1ps
`default_nettype none
module transceiver_power_sequencer import seq_pkg::*; #(
  parameter int CAL_CYCLES = CAL_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  cfg_if.dev cfg,
  output logic rx_en_o,
  output logic tx_en_o,
  output logic synth_en_o,
  output logic xosc_en_o,
  output logic [3:0] osc_bias_o,
  output logic [7:0] freq_word_o,
  output logic [7:0] receive_bias_o,
  output logic [7:0] buffer_bias_o,
  output logic cal_done_o
);
  localparam int CW = $clog2(CAL_CYCLES + 1);
  if (CAL_CYCLES < 1) begin : g_chk
    $error("CAL_CYCLES must be at least 1");
  end
  logic [7:0] main_reg, cal_ctl_reg, freq_first_reg, freq_second_reg;
  logic [7:0] osc_bias_reg, rx_bias_reg, buf_bias_reg, rdata_reg;
  logic cal_busy_reg, cal_done_reg;
  logic [CW-1:0] cal_cnt_reg;
  logic wr, soft_rst;
  assign wr = !cfg.sel_n && cfg.we;
  assign soft_rst = !main_reg[MAIN_RESET_N];
  assign cfg.rdata = rdata_reg;
  assign cal_done_o = cal_done_reg;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_reg <= MAIN_RST;
    end else if (wr && cfg.addr == A_MAIN) begin
      main_reg <= cfg.wdata;
    end
  end
  // soft reset returns the frequency, bias and calibration control registers to their defaults
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || soft_rst) begin
      freq_first_reg <= FREQ_RST;
      freq_second_reg <= FREQ_RST;
      osc_bias_reg <= OSC_BIAS_RST;
      rx_bias_reg <= RX_BIAS_RST;
      buf_bias_reg <= BUF_BIAS_RST;
      cal_ctl_reg <= 8'h00;
    end else if (wr) begin
      case (cfg.addr)
        A_FREQ_FIRST: freq_first_reg <= cfg.wdata;
        A_FREQ_SECOND: freq_second_reg <= cfg.wdata;
        A_OSC_BIAS: osc_bias_reg <= cfg.wdata;
        A_RX_BIAS: rx_bias_reg <= cfg.wdata;
        A_BUF_BIAS: buf_bias_reg <= cfg.wdata;
        A_CAL: cal_ctl_reg <= {cfg.wdata[7:1], 1'b0};
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // restart during a run starts the count again
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || soft_rst) begin
      cal_busy_reg <= 1'b0;
      cal_done_reg <= 1'b0;
      cal_cnt_reg <= '0;
    end else if (wr && cfg.addr == A_CAL && cfg.wdata[CAL_START]) begin
      cal_busy_reg <= 1'b1;
      cal_done_reg <= 1'b0;
      cal_cnt_reg <= '0;
    end else if (cal_busy_reg) begin
      if (cal_cnt_reg == CW'(CAL_CYCLES - 1)) begin
        cal_busy_reg <= 1'b0;
        cal_done_reg <= 1'b1;
      end else begin
        cal_cnt_reg <= cal_cnt_reg + 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || soft_rst) begin
      rx_en_o <= 1'b0;
      tx_en_o <= 1'b0;
      synth_en_o <= 1'b0;
      xosc_en_o <= 1'b0;
    end else begin
      rx_en_o <= !main_reg[MAIN_RX_PD];
      tx_en_o <= !main_reg[MAIN_TX_PD];
      synth_en_o <= !main_reg[MAIN_SYNTH_PD];
      xosc_en_o <= !main_reg[MAIN_XOSC_PD];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_bias_o <= 4'h0;
      freq_word_o <= 8'h00;
      receive_bias_o <= 8'h00;
      buffer_bias_o <= 8'h00;
    end else begin
      osc_bias_o <= main_reg[MAIN_FREQ_SEL] ? osc_bias_reg[7:4] : osc_bias_reg[3:0];
      freq_word_o <= main_reg[MAIN_FREQ_SEL] ? freq_second_reg : freq_first_reg;
      receive_bias_o <= rx_bias_reg;
      buffer_bias_o <= buf_bias_reg;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (!cfg.sel_n) begin
      case (cfg.addr)
        A_MAIN: rdata_reg <= main_reg;
        A_CAL: rdata_reg <= cal_ctl_reg;
        A_FREQ_FIRST: rdata_reg <= freq_first_reg;
        A_FREQ_SECOND: rdata_reg <= freq_second_reg;
        A_OSC_BIAS: rdata_reg <= osc_bias_reg;
        A_RX_BIAS: rdata_reg <= rx_bias_reg;
        A_BUF_BIAS: rdata_reg <= buf_bias_reg;
        default: rdata_reg <= {6'h00, cal_busy_reg, cal_done_reg};
      endcase
    end
  end
endmodule
`default_nettype wire

//--- logic/unused_placeholder_none.sv
// intentionally empty: no additional design content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- testbench/seq_asserts.sv
// checker on the configuration link between controller and transceiver
// assumes seq_pkg is compiled first and both ends share clk_i
`timescale 1ns/1ps
`default_nettype none
module seq_asserts import seq_pkg::*; #(
  parameter int CAL_CYCLES = CAL_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sel_n,
  input wire logic we,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // margin covers the read latency of the status poll
  localparam int CAL_HI = CAL_CYCLES + 4;
  // main words the controller writes; wake opens only synth and crystal
  localparam logic [7:0] WAKE_RX = 8'h83;
  localparam logic [7:0] WAKE_TX = 8'h93;
  localparam logic [7:0] SETUP_RX = 8'h82;
  localparam logic [7:0] SETUP_TX = 8'h91;
  localparam logic [7:0] SETUP_PD = 8'h87;
  wire logic wr_main = !sel_n && we && addr == A_MAIN;
  wire logic wr_cal = !sel_n && we && addr == A_CAL && wdata[CAL_START];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////
  property p_soft_reset;
    wr_main && !wdata[MAIN_RESET_N] |=> wr_main && wdata == MAIN_RST;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not released");
  property p_cal_after_wake;
    wr_cal |-> $past(wr_main) && ($past(wdata) == WAKE_RX || $past(wdata) == WAKE_TX);
  endproperty
  a_cal_after_wake: assert property (p_cal_after_wake) else $error("cal without wake");
  property p_cal_poll;
    wr_cal |=> (!sel_n && !we && addr == A_STATUS) [*2];
  endproperty
  a_cal_poll: assert property (p_cal_poll) else $error("status not polled");
  property p_cal_wait;
    wr_cal |-> ##2 !rdata[STAT_CAL_DONE] ##[1:CAL_HI] rdata[STAT_CAL_DONE];
  endproperty
  a_cal_wait: assert property (p_cal_wait) else $error("calibration done timing");
  property p_wake_rx;
    wr_main && wdata == WAKE_RX |=> wr_cal || (wr_main && wdata == SETUP_RX);
  endproperty
  a_wake_rx: assert property (p_wake_rx) else $error("rx wake not followed");
  property p_wake_tx;
    wr_main && wdata == WAKE_TX |=> wr_cal || (wr_main && wdata == SETUP_TX);
  endproperty
  a_wake_tx: assert property (p_wake_tx) else $error("tx wake not followed");
  property p_settle_quiet;
    wr_main && (wdata == SETUP_RX || wdata == SETUP_TX) |=> sel_n [*2];
  endproperty
  a_settle_quiet: assert property (p_settle_quiet) else $error("access during settle");
  property p_pd_quiet;
    wr_main && wdata == SETUP_PD |=> sel_n [*2];
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("select low in power down");
  property p_no_status_write;
    !sel_n && we |-> addr != A_STATUS;
  endproperty
  a_no_status_write: assert property (p_no_status_write) else $error("status written");
  c_cal: cover property (wr_cal);
  c_rx_setup: cover property (wr_main && wdata == SETUP_RX);
  c_tx_setup: cover property (wr_main && wdata == SETUP_TX);
  c_pd: cover property (wr_main && wdata == SETUP_PD);
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// bench: axi4-lite master drives the controller, transceiver outputs judged
// assumes seq_pkg, cfg_if, both design ends and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench import seq_pkg::*;;
  // short settle counts keep the run small; lock shorter than turn-on
  localparam int TON = 40;
  localparam int LCK = 10;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic rx_en_o, tx_en_o, synth_en_o, xosc_en_o, cal_done_o;
  logic [3:0] osc_bias_o;
  logic [7:0] freq_word_o, receive_bias_o, buffer_bias_o;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  wire logic [3:0] en = {rx_en_o, tx_en_o, synth_en_o, xosc_en_o};
  always #2 clk_i = ~clk_i;
  cfg_if cfg_bus();
  transceiver_power_sequencer #(.CAL_CYCLES(8)) transceiver_power_sequencer_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg(cfg_bus), .rx_en_o(rx_en_o), .tx_en_o(tx_en_o),
    .synth_en_o(synth_en_o), .xosc_en_o(xosc_en_o), .osc_bias_o(osc_bias_o),
    .freq_word_o(freq_word_o), .receive_bias_o(receive_bias_o),
    .buffer_bias_o(buffer_bias_o), .cal_done_o(cal_done_o));
  power_seq_host #(.TURN_ON_CYCLES(TON), .LOCK_CYCLES(LCK)) power_seq_host_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cfg(cfg_bus));
  seq_asserts #(.CAL_CYCLES(8)) seq_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sel_n(cfg_bus.sel_n), .we(cfg_bus.we), .addr(cfg_bus.addr), .wdata(cfg_bus.wdata),
    .rdata(cfg_bus.rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // ready taken at the rising edge of the handshake, response at a later edge once valid, each released right after it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk_i); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk_i); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_idle(output logic [31:0] st);
    logic [1:0] r;
    st = 32'h1;
    while (st[0] !== 1'b0) axi_rd(R_STATUS, st, r);
  endtask
  task automatic move(input int b, output logic [31:0] st, output int n);
    logic [1:0] r;
    int c0;
    axi_wr(R_CTRL, 32'h1 << b, r);
    c0 = cyc;
    wait_idle(st);
    n = cyc - c0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk(en, 4'h0, "enables at reset");
    chk(osc_bias_o, OSC_BIAS_RST[3:0], "osc bias at reset");
    chk({receive_bias_o, buffer_bias_o}, {RX_BIAS_RST, BUF_BIAS_RST}, "biases");
    chk(cal_done_o, 1'b0, "cal done at reset");
    axi_rd(R_BIAS, d, r);
    chk(d, BIAS_RST, "bias reg");
    // masked low byte must survive a zero write
    wstrb <= 4'he;
    axi_wr(R_TURN_ON, 32'h0, r);
    wstrb <= 4'hf;
    axi_rd(R_TURN_ON, d, r);
    chk(d, TON, "turn-on reg");
    axi_rd(8'h14, d, r);
    chk(r, RESP_SLVERR, "unmapped read");
    axi_wr(8'h20, 32'h0, r);
    chk(r, RESP_SLVERR, "unmapped write");
    axi_wr(R_STATUS, 32'hff, r);
    chk(r, RESP_OKAY, "status write");
    axi_wr(R_CTRL, 32'h1 << CTRL_RX, r);
    axi_rd(R_STATUS, d, r);
    chk(d[1:0], 2'b00, "rx before init");
  endtask
  task automatic t_init();
    logic [31:0] st;
    logic [1:0] r;
    int n;
    axi_wr(R_BIAS, 32'h0055_66a7, r);
    move(CTRL_INIT, st, n);
    chk(st[3:0], 4'b0010, "init status");
    chk(en, 4'b0001, "pd enables");
    chk({receive_bias_o, buffer_bias_o}, 16'h6655, "programmed biases");
    chk(cal_done_o, 1'b1, "calibrated");
  endtask
  task automatic t_pd_rx();
    logic [31:0] st;
    int n;
    move(CTRL_RX, st, n);
    chk(st[3:0], 4'b0110, "rx status");
    chk(en, 4'b1011, "rx enables");
    chk(osc_bias_o, 4'h7, "rx word bias");
    chk(n >= TON, 1'b1, "turn-on wait");
  endtask
  task automatic t_rx_tx();
    logic [31:0] st;
    int n;
    move(CTRL_TX, st, n);
    chk(st[3:0], 4'b1010, "tx status");
    chk(en, 4'b0111, "tx enables");
    chk(osc_bias_o, 4'ha, "tx word bias");
    chk(n >= LCK && n < TON, 1'b1, "lock wait");
  endtask
  task automatic t_tx_rx();
    logic [31:0] st;
    int n;
    move(CTRL_RX, st, n);
    chk(st[3:0], 4'b0110, "rx status");
    chk(en, 4'b1011, "rx enables");
    chk(n >= LCK && n < TON, 1'b1, "lock wait");
  endtask
  task automatic t_pd_tx();
    logic [31:0] st;
    int n;
    move(CTRL_PD, st, n);
    chk(st[3:0], 4'b0010, "pd status");
    chk(en, 4'b0001, "pd enables");
    move(CTRL_TX, st, n);
    chk(st[3:0], 4'b1010, "tx status");
    chk(en, 4'b0111, "tx enables");
    chk(freq_word_o, FREQ_RST, "tx freq word");
    chk(n >= TON, 1'b1, "turn-on wait");
  endtask
  task automatic t_reinit();
    logic [31:0] st;
    logic [1:0] r;
    logic seen;
    seen = 1'b0;
    axi_wr(R_CTRL, 32'h1 << CTRL_INIT, r);
    repeat (10) begin
      @(negedge clk_i);
      if (synth_en_o === 1'b0 && cal_done_o === 1'b0) seen = 1'b1;
    end
    chk(seen, 1'b1, "soft reset powers down");
    wait_idle(st);
    chk(st[3:0], 4'b0010, "reinit status");
    chk({receive_bias_o, buffer_bias_o}, 16'h6655, "biases rewritten");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_init();
    t_pd_rx();
    t_rx_tx();
    t_tx_rx();
    t_pd_tx();
    t_reinit();
    test_done();
  end
endmodule
`default_nettype wire
